// *** src/atsm_matrix.sv ***
// Arc trip scheme matrix: sensor to relay mapping, breaker-failure backup, push button decode

// How it works
// - Scheme 1, channels 1-3: relays 1,2 and fast
// - Scheme 1, channels 4-15: all relays, light signal, fast
// - Scheme 1, external light: all relays, fast, quench with overcurrent; no light signal
// - Scheme 1: every light source raises fast output
// - Scheme 1 quench: channels 3-15 and external light
// - Relays need light-only or overcurrent (not scheme 4 external); fast needs it in schemes 1,2 only
// - Quench contributions always need overcurrent
// - Scheme 2 channel 1: relays 1,2, signal, fast
// - Scheme 2 channel 2: relays 1-3, signal, fast
// - Scheme 2 channels 3-13,15: relays 1,3, quench
// - Scheme 2 tie channel 14: relays 1,3,4
// - Scheme 3 channels 11-14: one relay each
// - Schemes 3,4: persisting fault raises light signal
// - Scheme 3 channels 1-10,15: signal and fast only
// - Schemes 3,4 never drive quench control
// - Scheme 4 external input: ungated master trip
// - Scheme 4 maps channels like scheme 3
// - Push button: setup, clear, release, connection check
// - Three weighted switches select the scheme
// - Switch selects light only or light plus overcurrent
// - Backup fires after 150 ms of gated fault
// - Latch switch holds relays and fast until button
module atsm_matrix #(
    parameter int BFB_CYCLES = atsm_pkg::BFB_CYCLES,
    parameter int HOLD_CYCLES = atsm_pkg::HOLD_CYCLES,
    parameter int WIN_CYCLES = atsm_pkg::WIN_CYCLES
) (
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire logic [14:0] light_sensor_channels_in,
    input wire logic overcurrent_in,
    input wire logic external_light_in,
    input wire logic button_in,
    input wire logic [2:0] scheme_sel_in,
    input wire logic light_only_in,
    input wire logic latch_en_in,
    output logic [3:0] trip_relays_out,
    output logic light_signal_out,
    output logic fast_output_out,
    output logic quench_control_out,
    output logic setup_start_out,
    output logic lamp_clear_out,
    output logic latch_release_out,
    output logic conn_check_out
);

    localparam logic [atsm_pkg::CNT_W-1:0] BFB_LAST = atsm_pkg::CNT_W'(BFB_CYCLES - 1);
    localparam logic [atsm_pkg::CNT_W-1:0] HOLD_LAST = atsm_pkg::CNT_W'(HOLD_CYCLES - 1);
    localparam logic [atsm_pkg::CNT_W-1:0] WIN_LAST = atsm_pkg::CNT_W'(WIN_CYCLES - 1);

    atsm_pkg::atsm_state_s st;
    atsm_pkg::atsm_state_s next_st;
    logic [atsm_pkg::PIN_W-1:0] pins;
    logic [14:0] sens;
    logic oc;
    logic ext;
    logic btn;
    logic [2:0] sc;
    logic gate;
    logic latch;
    logic far_light;
    logic bf_fault;
    logic [3:0] t;
    logic bo;
    logic hf;
    logic aq;

    // ********************************
    // Input decode
    // ********************************
    // All pins pass two flops before use
    assign pins = {latch_en_in, light_only_in, scheme_sel_in, button_in,
                   external_light_in, overcurrent_in, light_sensor_channels_in};
    assign sens = st.sync2[14:0];
    assign oc = st.sync2[atsm_pkg::PIN_OC];
    assign ext = st.sync2[atsm_pkg::PIN_EXT];
    assign btn = st.sync2[atsm_pkg::PIN_BTN];
    assign sc = st.sync2[atsm_pkg::PIN_SCH +: 3];
    assign gate = st.sync2[atsm_pkg::PIN_LO] | oc;
    assign latch = st.sync2[atsm_pkg::PIN_LAT];
    assign far_light = (|sens[9:0]) | sens[14];
    assign bf_fault = (sc == atsm_pkg::SCH_3 || sc == atsm_pkg::SCH_4) && gate && (|sens[13:10]);

    // ********************************
    // Next state
    // ********************************
    always_comb
    begin
        next_st = st;
        next_st.sync1 = pins;
        next_st.sync2 = st.sync1;
        next_st.setup = 1'b0;
        next_st.clear = 1'b0;
        next_st.check = 1'b0;
        t = 4'h0;
        bo = 1'b0;
        hf = 1'b0;
        aq = 1'b0;

        // Scheme matrices
        case (sc)
            atsm_pkg::SCH_1:
            begin
                if (gate && (|sens[2:0]))
                begin
                    t = t | 4'h3;
                    hf = 1'b1;
                end
                if (gate && ((|sens[14:3]) || ext))
                begin
                    t = 4'hF;
                    hf = 1'b1;
                end
                bo = |sens[14:3];
                aq = oc && ((|sens[14:2]) || ext);
            end
            atsm_pkg::SCH_2:
            begin
                if (gate)
                begin
                    if (sens[0])
                        t = t | 4'h3;
                    if (sens[1])
                        t = t | 4'h7;
                    if ((|sens[12:2]) || sens[14] || ext)
                        t = t | 4'h5;
                    if (sens[13])
                        t = t | 4'hD;
                    hf = (|sens) || ext;
                end
                bo = |sens;
                aq = oc && (|sens[14:2]);
            end
            atsm_pkg::SCH_3, atsm_pkg::SCH_4:
            begin
                if (gate)
                    t = sens[13:10];
                if (ext && (gate || sc == atsm_pkg::SCH_4))
                    t = 4'hF;
                hf = far_light || ext;
                bo = far_light || st.bf_hit;
                aq = 1'b0;
            end
            default:
            begin
                t = 4'h0;
            end
        endcase

        // Relays and fast: OR of contributions, held when latching unless released
        next_st.trip = t | ((latch && !st.clear) ? st.trip : 4'h0);
        next_st.fast = hf | (latch && !st.clear && st.fast);
        next_st.bo = bo;
        next_st.quench = aq;

        // Breaker-failure backup timer
        if (!bf_fault)
        begin
            next_st.bf_cnt = '0;
            next_st.bf_hit = 1'b0;
        end
        else if (st.bf_cnt == BFB_LAST)
            next_st.bf_hit = 1'b1;
        else
            next_st.bf_cnt = st.bf_cnt + 1'b1;

        // Push button decode
        if (st.btn != atsm_pkg::BTN_IDLE && st.win_cnt != WIN_LAST)
            next_st.win_cnt = st.win_cnt + 1'b1;
        case (st.btn)
            atsm_pkg::BTN_IDLE:
            begin
                if (btn)
                begin
                    next_st.btn = atsm_pkg::BTN_DOWN;
                    next_st.presses = 2'h1;
                    next_st.win_cnt = '0;
                    next_st.hold_cnt = '0;
                end
            end
            atsm_pkg::BTN_DOWN:
            begin
                if (!btn)
                begin
                    next_st.clear = 1'b1;
                    if (st.presses == atsm_pkg::PRESS_CHECK && st.win_cnt != WIN_LAST)
                    begin
                        next_st.check = 1'b1;
                        next_st.btn = atsm_pkg::BTN_IDLE;
                    end
                    else
                        next_st.btn = atsm_pkg::BTN_WAIT;
                end
                else if (st.hold_cnt == HOLD_LAST)
                begin
                    next_st.setup = 1'b1;
                    next_st.btn = atsm_pkg::BTN_HELD;
                end
                else
                    next_st.hold_cnt = st.hold_cnt + 1'b1;
            end
            atsm_pkg::BTN_HELD:
            begin
                if (!btn)
                    next_st.btn = atsm_pkg::BTN_IDLE;
            end
            atsm_pkg::BTN_WAIT:
            begin
                if (st.win_cnt == WIN_LAST)
                    next_st.btn = atsm_pkg::BTN_IDLE;
                else if (btn)
                begin
                    next_st.btn = atsm_pkg::BTN_DOWN;
                    next_st.hold_cnt = '0;
                    if (st.presses != atsm_pkg::PRESS_CHECK)
                        next_st.presses = st.presses + 1'b1;
                end
            end
            default:
            begin
                next_st.btn = atsm_pkg::BTN_IDLE;
            end
        endcase
    end

    // ********************************
    // State register
    // ********************************
    always_ff @(posedge ref_clk_in)
    begin
        if (!rst_n_in)
            st <= atsm_pkg::ST_RESET;
        else
            st <= next_st;
    end

    // Outputs straight from flops
    assign trip_relays_out = st.trip;
    assign light_signal_out = st.bo;
    assign fast_output_out = st.fast;
    assign quench_control_out = st.quench;
    assign setup_start_out = st.setup;
    assign lamp_clear_out = st.clear;
    assign latch_release_out = st.clear;
    assign conn_check_out = st.check;

    // ********************************
    // Checks
    // ********************************
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rst_n_in);

    sequence s_fault_rise;
        !bf_fault ##1 bf_fault;
    endsequence

    a_s1_low_relays: assert property (
        sc == atsm_pkg::SCH_1 && !latch && gate && sens[0] && !(|sens[14:3]) && !ext
        |=> trip_relays_out == 4'h3 && fast_output_out && !light_signal_out)
        else $error("scheme 1 low channel mapping wrong");
    a_s1_high_relays: assert property (
        sc == atsm_pkg::SCH_1 && gate && sens[5] |=> trip_relays_out == 4'hF && light_signal_out)
        else $error("scheme 1 high channel mapping wrong");
    a_s1_ext_light: assert property (
        sc == atsm_pkg::SCH_1 && gate && ext && !(|sens) |=> trip_relays_out == 4'hF && !light_signal_out)
        else $error("scheme 1 external light mapping wrong");
    a_s1_quench_low: assert property (
        sc == atsm_pkg::SCH_1 && !(|sens[14:2]) && !ext |=> !quench_control_out)
        else $error("channels 1 and 2 drove quench");
    a_gate_blocks: assert property (
        !gate && !latch && !(sc == atsm_pkg::SCH_4 && ext) |=> trip_relays_out == 4'h0)
        else $error("ungated relay contribution");
    a_quench_oc: assert property (
        quench_control_out |-> $past(oc))
        else $error("quench without overcurrent");
    a_s2_tie_chan: assert property (
        sc == atsm_pkg::SCH_2 && gate && sens[13] |=> trip_relays_out[3] && trip_relays_out[0])
        else $error("tie channel mapping wrong");
    a_s3_one_relay: assert property (
        sc == atsm_pkg::SCH_3 && !latch && gate && !ext && sens[13:10] == 4'h2 |=> trip_relays_out == 4'h2)
        else $error("feeder channel relay wrong");
    a_no_quench_34: assert property (
        sc == atsm_pkg::SCH_3 || sc == atsm_pkg::SCH_4 |=> !quench_control_out)
        else $error("quench in scheme 3 or 4");
    a_master_trip: assert property (
        sc == atsm_pkg::SCH_4 && ext |=> trip_relays_out == 4'hF && fast_output_out)
        else $error("master trip missed");
    a_bfb_delay: assert property (
        s_fault_rise |-> !st.bf_hit ##1 !st.bf_hit)
        else $error("backup fired early");
    a_bfb_count: assert property (
        $rose(st.bf_hit) |-> $past(st.bf_cnt) == BFB_LAST && $past(bf_fault))
        else $error("backup timing wrong");
    a_latch_hold: assert property (
        latch && st.trip[0] && !st.clear |=> trip_relays_out[0])
        else $error("latched relay dropped");

endmodule : atsm_matrix

// *** src/atsm_pkg.sv ***
// Shared constants and state types of the arc trip scheme matrix
package atsm_pkg;

    // ********************************
    // Timing
    // ********************************
    localparam int CLK_HZ = 40_000_000;
    localparam int BFB_TIME_MS = 150;
    localparam int BFB_CYCLES = BFB_TIME_MS * (CLK_HZ / 1000);
    localparam int HOLD_TIME_MS = 2000;
    localparam int HOLD_CYCLES = HOLD_TIME_MS * (CLK_HZ / 1000);
    localparam int WIN_TIME_MS = 2000;
    localparam int WIN_CYCLES = WIN_TIME_MS * (CLK_HZ / 1000);
    localparam int CNT_W = 27;

    // ********************************
    // Scheme numbers and pin vector layout
    // ********************************
    localparam logic [2:0] SCH_1 = 3'h1;
    localparam logic [2:0] SCH_2 = 3'h2;
    localparam logic [2:0] SCH_3 = 3'h3;
    localparam logic [2:0] SCH_4 = 3'h4;
    localparam int PIN_OC = 15;
    localparam int PIN_EXT = 16;
    localparam int PIN_BTN = 17;
    localparam int PIN_SCH = 18;
    localparam int PIN_LO = 21;
    localparam int PIN_LAT = 22;
    localparam int PIN_W = 23;
    localparam logic [1:0] PRESS_CHECK = 2'h3;

    // ********************************
    // Types
    // ********************************
    typedef enum logic [1:0] {
        BTN_IDLE = 2'b00,
        BTN_DOWN = 2'b01,
        BTN_HELD = 2'b10,
        BTN_WAIT = 2'b11
    } atsm_btn_e;

    typedef struct packed {
        logic [PIN_W-1:0] sync1;
        logic [PIN_W-1:0] sync2;
        logic [3:0] trip;
        logic bo;
        logic fast;
        logic quench;
        logic [CNT_W-1:0] bf_cnt;
        logic bf_hit;
        atsm_btn_e btn;
        logic [CNT_W-1:0] hold_cnt;
        logic [CNT_W-1:0] win_cnt;
        logic [1:0] presses;
        logic setup;
        logic clear;
        logic check;
    } atsm_state_s;

    localparam atsm_state_s ST_RESET = '0;

endpackage : atsm_pkg

// *** test/atsm_field.sv ***
// Field side model: light sensors, overcurrent relay and upstream light or master-trip source
module atsm_field (
    input wire logic [14:0] lit_in,
    input wire logic oc_in,
    input wire logic ext_in,
    output logic [14:0] light_sensor_channels_out,
    output logic overcurrent_out,
    output logic external_light_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // Sensors and relays give steady levels and never release their lines
    assign light_sensor_channels_out = lit_in;
    assign overcurrent_out = oc_in;
    assign external_light_out = ext_in;
endmodule : atsm_field

// *** test/atsm_matrix_test.sv ***
// Self-checking bench of the arc trip scheme matrix
module atsm_matrix_test;
    timeunit 1ns;
    timeprecision 1ps;
    // ********************************
    // Signals and instances
    // ********************************
    localparam int BFB = 20;
    logic ref_clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic [14:0] lit = 15'h0000;
    logic oc = 1'b0;
    logic ext = 1'b0;
    logic btn = 1'b0;
    logic [2:0] sch = 3'h0;
    logic lo = 1'b0;
    logic lat = 1'b0;
    logic [14:0] sens;
    logic oc_pin;
    logic ext_pin;
    logic [3:0] trip;
    logic sig;
    logic fast;
    logic quench;
    logic setup;
    logic clr;
    logic rel;
    logic conn;
    logic [6:0] outs;
    int error_cnt = 0;
    int num_checks = 0;
    int clr_cnt = 0;
    int rel_cnt = 0;
    int conn_cnt = 0;
    int set_cnt = 0;
    assign outs = {trip, sig, fast, quench};
    // Clock of 25 ns
    always #12.5 ref_clk_in = ~ref_clk_in;
    atsm_field atsm_field_inst (.lit_in(lit), .oc_in(oc), .ext_in(ext), .light_sensor_channels_out(sens),
        .overcurrent_out(oc_pin), .external_light_out(ext_pin));
    atsm_matrix #(.BFB_CYCLES(BFB), .HOLD_CYCLES(40), .WIN_CYCLES(100)) atsm_matrix_inst (
        .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .light_sensor_channels_in(sens),
        .overcurrent_in(oc_pin), .external_light_in(ext_pin), .button_in(btn), .scheme_sel_in(sch),
        .light_only_in(lo), .latch_en_in(lat), .trip_relays_out(trip), .light_signal_out(sig),
        .fast_output_out(fast), .quench_control_out(quench), .setup_start_out(setup),
        .lamp_clear_out(clr), .latch_release_out(rel), .conn_check_out(conn));
    // Counts the one-cycle button pulses mid-cycle, where they are settled
    always @(negedge ref_clk_in)
    begin
        if (clr === 1'b1) clr_cnt++;
        if (rel === 1'b1) rel_cnt++;
        if (conn === 1'b1) conn_cnt++;
        if (setup === 1'b1) set_cnt++;
    end
    // ********************************
    // Shared tasks
    // ********************************
    task check(input string name, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp)
        begin
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
            error_cnt++;
        end
    endtask : check
    // Drives one input set, waits past the three-edge path, compares relay, signal, fast and quench outputs
    task apply(input logic [2:0] s, input logic l, input logic [14:0] c, input logic o, input logic e,
        input logic [6:0] exp, input string name);
        @(negedge ref_clk_in);
        sch = s;
        lo = l;
        lit = c;
        oc = o;
        ext = e;
        repeat (4) @(negedge ref_clk_in);
        check(name, {1'b0, exp}, {1'b0, outs});
    endtask : apply
    task press(input int n);
        @(negedge ref_clk_in);
        btn = 1'b1;
        repeat (n) @(negedge ref_clk_in);
        btn = 1'b0;
        repeat (6) @(negedge ref_clk_in);
    endtask : press
    // Holds a channel 11-14 fault and measures when the light signal rises
    task bfb_delay(input logic [2:0] s, input logic [14:0] c, input logic [6:0] exp);
        int k;
        apply(s, 1'b0, c, 1'b1, 1'b0, exp, "bfb trip");
        k = 4;
        while (sig !== 1'b1 && k < 40)
        begin
            @(negedge ref_clk_in);
            k++;
        end
        check("bfb delay", 8'h17, 8'(k));
    endtask : bfb_delay
    task end_sim;
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : end_sim
    // ********************************
    // Scenarios
    // ********************************
    task s_scheme1;
        apply(atsm_pkg::SCH_1, 1'b1, 15'h0001, 1'b0, 1'b0, 7'h1A, "s1 ch1");
        apply(atsm_pkg::SCH_1, 1'b0, 15'h0002, 1'b0, 1'b0, 7'h00, "s1 ch2 gated");
        apply(atsm_pkg::SCH_1, 1'b0, 15'h0004, 1'b1, 1'b0, 7'h1B, "s1 ch3 oc");
        apply(atsm_pkg::SCH_1, 1'b0, 15'h4000, 1'b1, 1'b0, 7'h7F, "s1 ch15");
        apply(atsm_pkg::SCH_1, 1'b1, 15'h0020, 1'b0, 1'b0, 7'h7E, "s1 ch6 light only");
        apply(atsm_pkg::SCH_1, 1'b1, 15'h0000, 1'b0, 1'b1, 7'h7A, "s1 ext");
        apply(atsm_pkg::SCH_1, 1'b0, 15'h0008, 1'b0, 1'b0, 7'h04, "s1 ch4 gated");
    endtask : s_scheme1
    task s_scheme2;
        apply(atsm_pkg::SCH_2, 1'b1, 15'h0001, 1'b1, 1'b0, 7'h1E, "s2 ch1");
        apply(atsm_pkg::SCH_2, 1'b1, 15'h0002, 1'b1, 1'b0, 7'h3E, "s2 ch2");
        apply(atsm_pkg::SCH_2, 1'b1, 15'h0010, 1'b1, 1'b0, 7'h2F, "s2 ch5");
        apply(atsm_pkg::SCH_2, 1'b1, 15'h2000, 1'b1, 1'b0, 7'h6F, "s2 ch14");
        apply(atsm_pkg::SCH_2, 1'b1, 15'h0000, 1'b0, 1'b1, 7'h2A, "s2 ext");
    endtask : s_scheme2
    task s_scheme34;
        apply(atsm_pkg::SCH_3, 1'b1, 15'h0400, 1'b1, 1'b0, 7'h08, "s3 ch11");
        apply(atsm_pkg::SCH_3, 1'b1, 15'h2000, 1'b1, 1'b0, 7'h40, "s3 ch14");
        apply(atsm_pkg::SCH_3, 1'b0, 15'h0001, 1'b1, 1'b0, 7'h06, "s3 ch1");
        apply(atsm_pkg::SCH_3, 1'b0, 15'h4000, 1'b0, 1'b0, 7'h06, "s3 ch15");
        apply(atsm_pkg::SCH_3, 1'b0, 15'h0000, 1'b0, 1'b1, 7'h02, "s3 ext gated");
        apply(atsm_pkg::SCH_3, 1'b1, 15'h0000, 1'b0, 1'b1, 7'h7A, "s3 ext");
        apply(atsm_pkg::SCH_3, 1'b0, 15'h0000, 1'b0, 1'b0, 7'h00, "idle");
        bfb_delay(atsm_pkg::SCH_3, 15'h0800, 7'h10);
        apply(atsm_pkg::SCH_3, 1'b0, 15'h0800, 1'b0, 1'b0, 7'h00, "bfb gated");
        repeat (30) @(negedge ref_clk_in);
        check("bfb gated", 8'h00, {1'b0, outs});
        apply(atsm_pkg::SCH_4, 1'b0, 15'h0000, 1'b0, 1'b1, 7'h7A, "s4 master");
        apply(atsm_pkg::SCH_4, 1'b0, 15'h0000, 1'b0, 1'b0, 7'h00, "idle");
        bfb_delay(atsm_pkg::SCH_4, 15'h1000, 7'h20);
        apply(3'h0, 1'b1, 15'h0008, 1'b1, 1'b1, 7'h00, "scheme 0");
        apply(3'h5, 1'b1, 15'h0008, 1'b1, 1'b1, 7'h00, "scheme 5");
    endtask : s_scheme34
    task s_latch;
        lat = 1'b1;
        apply(atsm_pkg::SCH_1, 1'b1, 15'h0001, 1'b0, 1'b0, 7'h1A, "latch set");
        apply(atsm_pkg::SCH_1, 1'b1, 15'h0000, 1'b0, 1'b0, 7'h1A, "latch hold");
        press(3);
        check("latch release", 8'h00, {1'b0, outs});
        check("release pulse", 8'h01, 8'(rel_cnt));
        lat = 1'b0;
    endtask : s_latch
    task s_button;
        repeat (110) @(negedge ref_clk_in);
        press(3);
        press(3);
        press(3);
        check("lamp clears", 8'h04, 8'(clr_cnt));
        check("conn check", 8'h01, 8'(conn_cnt));
        repeat (110) @(negedge ref_clk_in);
        press(50);
        check("setup pulse", 8'h01, 8'(set_cnt));
        check("no clear after hold", 8'h04, 8'(clr_cnt));
    endtask : s_button
    // Main sequence
    initial
    begin
        repeat (3) @(negedge ref_clk_in);
        rst_n_in = 1'b1;
        s_scheme1();
        s_scheme2();
        s_scheme34();
        s_latch();
        s_button();
        end_sim();
    end
endmodule : atsm_matrix_test
